/* rtl/usbrp_root_port.v */
// How it works
// RULE1: Config flag one routes ports here.
// RULE2: Software sets config flag last.
// RULE3: Reserved bits read zero, ignore writes.
// RULE4: Three enables select wake events.
// RULE5: Zero test select means no test.
// RULE6: Flag rising forces ownership bit zero.
// RULE7: Ownership held one while flag zero.
// RULE8: Software hands away non-high-speed devices.
// RULE9: Port power bit is read-only one.
// RULE10: Line field shows D+ high, D- low.
// RULE11: Reset write one starts bus reset.
// RULE12: Reset write zero ends reset signalling.
// RULE13: Suspend write one suspends; zero ignored.
// RULE14: Resume fall or reset clears suspend.
// RULE15: Resume drives K; J-to-K sets it.
// RULE16: Resume write zero completes resume.
// RULE17: Over-current change sets; write-one clears.
// RULE18: Over-current active mirrors condition.
// RULE19: Enable change only on EOF2 disable.
// RULE20: Only controller enables; faults/software disable.
// RULE21: Attach change sets on change; W1C.
// RULE22: Attach state mirrors device presence.
`timescale 1ns/1ps
`default_nettype none
`include "usbrp_defines.vh"
module usbrp_root_port
(
   input wire sys_clk,
   input wire arst_n,
   input wire [7:0] s_axi_awaddr,
   input wire s_axi_awvalid,
   output wire s_axi_awready,
   input wire [31:0] s_axi_wdata,
   input wire [3:0] s_axi_wstrb,
   input wire s_axi_wvalid,
   output wire s_axi_wready,
   output reg [1:0] s_axi_bresp,
   output reg s_axi_bvalid,
   input wire s_axi_bready,
   input wire [7:0] s_axi_araddr,
   input wire s_axi_arvalid,
   output wire s_axi_arready,
   output reg [31:0] s_axi_rdata,
   output reg [1:0] s_axi_rresp,
   output reg s_axi_rvalid,
   input wire s_axi_rready,
   input wire attachPin,
   input wire overcurrentPin,
   input wire linePlusPin,
   input wire lineMinusPin,
   input wire eof2Disable,
   input wire resetDoneHighSpeed,
   output reg routeToThisCtrl,
   output reg busResetDrive,
   output reg suspendDrive,
   output reg resumeDrive,
   output reg [3:0] testSelect,
   output reg wakeEvent
);

   // ------------------------------------------------------------
   // Pin synchronisers
   // ------------------------------------------------------------
   // Two flops per pin; only the second stage is read by logic.
   wire [3:0] pinRaw;
   reg [3:0] pinMeta_q;
   reg [3:0] pinSync_q;
   assign pinRaw = {lineMinusPin, linePlusPin, overcurrentPin, attachPin};
   genvar gi;
   generate
      for (gi = 0; gi < 4; gi = gi + 1)
      begin : gSync
         always @(posedge sys_clk or negedge arst_n)
         begin
            if (!arst_n)
            begin
               pinMeta_q[gi] <= 1'b0;
               pinSync_q[gi] <= 1'b0;
            end
            else
            begin
               pinMeta_q[gi] <= pinRaw[gi];
               pinSync_q[gi] <= pinMeta_q[gi];
            end
         end
      end
   endgenerate
   wire attachNow = pinSync_q[0];
   wire ocNow = pinSync_q[1];
   wire [1:0] lineNow = {pinSync_q[2], pinSync_q[3]}; // D+ upper, D- lower. [RULE10]

   // ------------------------------------------------------------
   // AXI4-Lite write path
   // ------------------------------------------------------------
   // Address and data latch separately so the master may offer either first.
   reg awHeld_q;
   reg wHeld_q;
   reg [7:0] awAddr_q;
   reg [31:0] wData_q;
   reg [3:0] wStrb_q;
   assign s_axi_awready = !awHeld_q && !s_axi_bvalid;
   assign s_axi_wready = !wHeld_q && !s_axi_bvalid;
   wire wrFire = awHeld_q && wHeld_q && !s_axi_bvalid;
   wire wrCfg = wrFire && awAddr_q == `USBRP_OFF_CFGFLAG;
   wire wrPort = wrFire && awAddr_q == `USBRP_OFF_PORTCTL;
   wire wrKnown = wrCfg || wrPort || awAddr_q == `USBRP_OFF_PORTSIG;
   // Only byte lanes with strobes set take effect.
   wire [31:0] wMask = {{8{wStrb_q[3]}}, {8{wStrb_q[2]}}, {8{wStrb_q[1]}}, {8{wStrb_q[0]}}};
   wire [31:0] portW1 = wrPort ? (wData_q & wMask) : 32'h00000000;
   wire [31:0] portW0 = wrPort ? (~wData_q & wMask) : 32'h00000000;

   always @(posedge sys_clk or negedge arst_n)
   begin
      if (!arst_n)
      begin
         awHeld_q <= 1'b0;
         wHeld_q <= 1'b0;
         awAddr_q <= 8'h00;
         wData_q <= 32'h00000000;
         wStrb_q <= 4'h0;
         s_axi_bvalid <= 1'b0;
         s_axi_bresp <= `USBRP_RESP_OKAY;
      end
      else
      begin
         if (s_axi_awvalid && s_axi_awready)
         begin
            awHeld_q <= 1'b1;
            awAddr_q <= {s_axi_awaddr[7:2], 2'b00};
         end
         if (s_axi_wvalid && s_axi_wready)
         begin
            wHeld_q <= 1'b1;
            wData_q <= s_axi_wdata;
            wStrb_q <= s_axi_wstrb;
         end
         if (wrFire)
         begin
            awHeld_q <= 1'b0;
            wHeld_q <= 1'b0;
            s_axi_bvalid <= 1'b1;
            s_axi_bresp <= wrKnown ? `USBRP_RESP_OKAY : `USBRP_RESP_SLVERR;
         end
         else if (s_axi_bvalid && s_axi_bready)
         begin
            s_axi_bvalid <= 1'b0;
         end
      end
   end

   // ------------------------------------------------------------
   // Configure flag and ownership
   // ------------------------------------------------------------
   reg cfgDone_q;
   reg handoff_q;
   wire cfgDone_d = (wrCfg && wStrb_q[0]) ? wData_q[0] : cfgDone_q;
   always @(posedge sys_clk or negedge arst_n)
   begin
      if (!arst_n)
      begin
         cfgDone_q <= 1'b0;
         handoff_q <= 1'b1;
         routeToThisCtrl <= 1'b0;
      end
      else
      begin
         cfgDone_q <= cfgDone_d;
         routeToThisCtrl <= cfgDone_q; // [RULE1]
         if (!cfgDone_q)
            handoff_q <= 1'b1; // [RULE7]
         else if (cfgDone_d && !cfgDone_q)
            handoff_q <= 1'b0;
         else if (wrPort && wStrb_q[1])
            handoff_q <= wData_q[`USBRP_B_HANDOFF];
         if (cfgDone_d && !cfgDone_q)
            handoff_q <= 1'b0; // Rising flag wins over everything. [RULE6]
      end
   end

   // ------------------------------------------------------------
   // Port state
   // ------------------------------------------------------------
   reg [2:0] wakeEn_q;
   reg busRst_q;
   reg susp_q;
   reg resume_q;
   reg ocChg_q;
   reg enChg_q;
   reg enabled_q;
   reg attChg_q;
   reg attPrev_q;
   reg ocPrev_q;
   reg jPrev_q;
   reg [`USBRP_CNT_W-1:0] rstCnt_q;
   wire rstMinDone = rstCnt_q == `USBRP_RESET_CYC;
   // J is D+ high (full-speed idle); K is D- high.
   wire lineK = lineNow == 2'b01;
   wire lineJ = lineNow == 2'b10;
   wire resumeFall = wrPort && wStrb_q[0] && resume_q && !wData_q[`USBRP_B_RESUME];
   wire rstStart = portW1[`USBRP_B_BUSRST];
   always @(posedge sys_clk or negedge arst_n)
   begin
      if (!arst_n)
      begin
         wakeEn_q <= 3'h0;
         testSelect <= 4'h0;
         busRst_q <= 1'b0;
         susp_q <= 1'b0;
         resume_q <= 1'b0;
         ocChg_q <= 1'b0;
         enChg_q <= 1'b0;
         enabled_q <= 1'b0;
         attChg_q <= 1'b0;
         attPrev_q <= 1'b0;
         ocPrev_q <= 1'b0;
         jPrev_q <= 1'b0;
         rstCnt_q <= {`USBRP_CNT_W{1'b0}};
      end
      else
      begin
         attPrev_q <= attachNow;
         ocPrev_q <= ocNow;
         jPrev_q <= lineJ;
         if (wrPort && wStrb_q[2])
         begin
            wakeEn_q <= wData_q[`USBRP_B_WAKEOC:`USBRP_B_WAKEATT]; // [RULE4]
            testSelect <= wData_q[`USBRP_F_TEST_HI:`USBRP_F_TEST_LO]; // [RULE5]
         end
         if (wrPort && wStrb_q[1])
            busRst_q <= wData_q[`USBRP_B_BUSRST]; // [RULE11] [RULE12]
         // Keep counting after an early clear so the minimum length is still driven.
         if ((busRst_q || rstCnt_q != {`USBRP_CNT_W{1'b0}}) && !rstMinDone)
            rstCnt_q <= rstCnt_q + 1'b1;
         else if (!busRst_q)
            rstCnt_q <= {`USBRP_CNT_W{1'b0}};
         // The controller enables at reset end if a high-speed device answered.
         if (busRst_q && wrPort && wStrb_q[1] && !wData_q[`USBRP_B_BUSRST])
            enabled_q <= attachNow && resetDoneHighSpeed; // [RULE20]
         else if (portW0[`USBRP_B_ENABLED] || !attachNow || rstStart)
            enabled_q <= 1'b0; // [RULE20]
         else if (eof2Disable && enabled_q)
            enabled_q <= 1'b0;
         if (rstStart || resumeFall)
            susp_q <= 1'b0; // [RULE14]
         else if (portW1[`USBRP_B_SUSP] && enabled_q)
            susp_q <= 1'b1; // [RULE13]
         if (susp_q && lineK && jPrev_q)
            resume_q <= 1'b1; // [RULE15]
         else if (wrPort && wStrb_q[0])
            resume_q <= wData_q[`USBRP_B_RESUME]; // [RULE16]
         // Set wins over write-one-to-clear in the same cycle.
         if (ocNow != ocPrev_q)
            ocChg_q <= 1'b1; // [RULE17]
         else if (portW1[`USBRP_B_OCCHG])
            ocChg_q <= 1'b0;
         if (eof2Disable && enabled_q)
            enChg_q <= 1'b1; // [RULE19]
         else if (portW1[`USBRP_B_ENCHG])
            enChg_q <= 1'b0;
         if (attachNow != attPrev_q)
            attChg_q <= 1'b1; // [RULE21]
         else if (portW1[`USBRP_B_ATTCHG])
            attChg_q <= 1'b0;
      end
   end

   // ------------------------------------------------------------
   // Line drive outputs and wake
   // ------------------------------------------------------------
   // Reset signalling stays on until software clears the bit, at least the minimum.
   always @(posedge sys_clk or negedge arst_n)
   begin
      if (!arst_n)
      begin
         busResetDrive <= 1'b0;
         suspendDrive <= 1'b0;
         resumeDrive <= 1'b0;
         wakeEvent <= 1'b0;
      end
      else
      begin
         busResetDrive <= busRst_q || (rstCnt_q != {`USBRP_CNT_W{1'b0}} && !rstMinDone); // [RULE12]
         suspendDrive <= susp_q && !resume_q;
         resumeDrive <= resume_q; // [RULE15]
         wakeEvent <= susp_q && ((wakeEn_q[2] && ocNow && !ocPrev_q)
            || (wakeEn_q[1] && !attachNow && attPrev_q)
            || (wakeEn_q[0] && attachNow && !attPrev_q)); // [RULE4]
      end
   end

   // ------------------------------------------------------------
   // Read path
   // ------------------------------------------------------------
   // Reserved bits are zero in every read image. [RULE3]
   wire [31:0] cfgImage = {31'h00000000, cfgDone_q};
   wire [31:0] portImage = {9'h000, wakeEn_q, testSelect, 2'b00, handoff_q,
      1'b1, lineNow, 1'b0, busRst_q, susp_q, resume_q, ocChg_q, ocNow,
      enChg_q, enabled_q, attChg_q, attachNow}; // [RULE9] [RULE18] [RULE22]
   assign s_axi_arready = !s_axi_rvalid;
   always @(posedge sys_clk or negedge arst_n)
   begin
      if (!arst_n)
      begin
         s_axi_rvalid <= 1'b0;
         s_axi_rdata <= 32'h00000000;
         s_axi_rresp <= `USBRP_RESP_OKAY;
      end
      else if (s_axi_arvalid && s_axi_arready)
      begin
         s_axi_rvalid <= 1'b1;
         s_axi_rresp <= `USBRP_RESP_OKAY;
         case ({s_axi_araddr[7:2], 2'b00})
            `USBRP_OFF_CFGFLAG: s_axi_rdata <= cfgImage;
            `USBRP_OFF_PORTCTL: s_axi_rdata <= portImage;
            `USBRP_OFF_PORTSIG: s_axi_rdata <= {28'h0000000, testSelect};
            default:
            begin
               s_axi_rdata <= 32'h00000000;
               s_axi_rresp <= `USBRP_RESP_SLVERR;
            end
         endcase
      end
      else if (s_axi_rvalid && s_axi_rready)
      begin
         s_axi_rvalid <= 1'b0;
      end
   end

endmodule
`default_nettype wire

/* pkg/usbrp_defines.vh */
`ifndef USBRP_DEFINES_VH
`define USBRP_DEFINES_VH
// ------------------------------------------------------------
// Register map
// ------------------------------------------------------------
`define USBRP_ADDR_W 8
`define USBRP_OFF_CFGFLAG 8'h60
`define USBRP_OFF_PORTCTL 8'h64
`define USBRP_OFF_PORTSIG 8'h68
`define USBRP_PORTCTL_RST 32'h00002000
// ------------------------------------------------------------
// Port control field positions
// ------------------------------------------------------------
`define USBRP_B_WAKEOC 22
`define USBRP_B_WAKEDET 21
`define USBRP_B_WAKEATT 20
`define USBRP_F_TEST_HI 19
`define USBRP_F_TEST_LO 16
`define USBRP_B_HANDOFF 13
`define USBRP_B_SUPPLY 12
`define USBRP_B_LINE_HI 11
`define USBRP_B_LINE_LO 10
`define USBRP_B_BUSRST 8
`define USBRP_B_SUSP 7
`define USBRP_B_RESUME 6
`define USBRP_B_OCCHG 5
`define USBRP_B_OCACT 4
`define USBRP_B_ENCHG 3
`define USBRP_B_ENABLED 2
`define USBRP_B_ATTCHG 1
`define USBRP_B_ATTACH 0
// ------------------------------------------------------------
// Bus answers and timing
// ------------------------------------------------------------
`define USBRP_RESP_OKAY 2'h0
`define USBRP_RESP_SLVERR 2'h2
// Minimum bus reset length kept even if software ends reset early.
`define USBRP_RESET_NS 10000
`define USBRP_CLK_NS 10
`define USBRP_RESET_CYC ((`USBRP_RESET_NS + `USBRP_CLK_NS - 1) / `USBRP_CLK_NS)
`define USBRP_CNT_W 11
`endif

/* test/usbrp_checker.sv */
`timescale 1ns/1ps
`default_nettype none
`include "usbrp_defines.vh"
module usbrp_checker
(
   input wire logic sys_clk,
   input wire logic arst_n,
   input wire logic s_axi_awready,
   input wire logic s_axi_wready,
   input wire logic s_axi_bvalid,
   input wire logic s_axi_bready,
   input wire logic s_axi_arvalid,
   input wire logic s_axi_arready,
   input wire logic s_axi_rvalid,
   input wire logic s_axi_rready,
   input wire logic busResetDrive,
   input wire logic suspendDrive,
   input wire logic wakeEvent
);
   logic [15:0] rstLen_q;
   default clocking cb @(posedge sys_clk);
   endclocking
   default disable iff (!arst_n);
   // Length of the bus reset so far, so that an early end can be seen.
   always_ff @(posedge sys_clk or negedge arst_n)
   begin
      if (!arst_n) rstLen_q <= 16'h0000;
      else rstLen_q <= busResetDrive ? rstLen_q + 16'h0001 : 16'h0000;
   end
   property p_bHold; s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid; endproperty
   a_bHold: assert property (p_bHold) else $error("bvalid dropped before bready");
   property p_rHold; s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid; endproperty
   a_rHold: assert property (p_rHold) else $error("rvalid dropped before rready");
   property p_awBlock; s_axi_bvalid |-> !s_axi_awready && !s_axi_wready; endproperty
   a_awBlock: assert property (p_awBlock) else $error("write taken while answer waits");
   property p_arBlock; s_axi_rvalid |-> !s_axi_arready; endproperty
   a_arBlock: assert property (p_arBlock) else $error("read taken while answer waits");
   property p_rdAns; s_axi_arvalid && s_axi_arready |=> s_axi_rvalid; endproperty
   a_rdAns: assert property (p_rdAns) else $error("read answer late");
   property p_rstLen; $fell(busResetDrive) |-> rstLen_q >= `USBRP_RESET_CYC; endproperty
   a_rstLen: assert property (p_rstLen) else $error("bus reset too short");
   property p_rstSusp; $rose(busResetDrive) |-> ##[0:3] !suspendDrive; endproperty
   a_rstSusp: assert property (p_rstSusp) else $error("suspend kept in reset");
   property p_wakeSusp; wakeEvent |-> $past(suspendDrive); endproperty
   a_wakeSusp: assert property (p_wakeSusp) else $error("wake while awake");
endmodule
bind usbrp_root_port usbrp_checker u_usbrp_checker
(
   .sys_clk(sys_clk), .arst_n(arst_n), .s_axi_awready(s_axi_awready),
   .s_axi_wready(s_axi_wready), .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready),
   .s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready), .s_axi_rvalid(s_axi_rvalid),
   .s_axi_rready(s_axi_rready), .busResetDrive(busResetDrive), .suspendDrive(suspendDrive),
   .wakeEvent(wakeEvent)
);
`default_nettype wire

/* test/usbrp_dev_model.sv */
`timescale 1ns/1ps
`default_nettype none
module usbrp_dev_model
(
   input wire logic present,
   input wire logic overCur,
   input wire logic wakeK,
   input wire logic busResetDrive,
   input wire logic resumeDrive,
   output logic attachPin,
   output logic overcurrentPin,
   output logic linePlusPin,
   output logic lineMinusPin
);
   // Host pull-downs give SE0 when detached or in reset; K wins over idle J.
   assign attachPin = present;
   assign overcurrentPin = overCur;
   assign linePlusPin = present && !busResetDrive && !(resumeDrive || wakeK);
   assign lineMinusPin = present && !busResetDrive && (resumeDrive || wakeK);
endmodule
`default_nettype wire

/* test/tb_top.sv */
`timescale 1ns/1ps
`default_nettype none
`include "usbrp_defines.vh"
`define CHK(n, e, g) \
   begin \
      checks++; \
      if ((g) !== (e)) \
      begin \
         n_errors++; \
         $display("BAD %s expected %h seen %h", n, e, g); \
      end \
   end
module tb_top;
   localparam logic [7:0] PC = `USBRP_OFF_PORTCTL;
   localparam logic [7:0] CFG = `USBRP_OFF_CFGFLAG;
   localparam logic [31:0] ALL = 32'hFFFFFFFF;
   localparam logic [1:0] OK = `USBRP_RESP_OKAY;
   logic sys_clk, arst_n, s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid;
   logic s_axi_rready, eof2Disable, resetDoneHighSpeed, present, overCur, wakeK, sawWake;
   logic [7:0] s_axi_awaddr, s_axi_araddr;
   logic [31:0] s_axi_wdata;
   logic [3:0] s_axi_wstrb;
   wire s_axi_awready, s_axi_wready, s_axi_arready, s_axi_bvalid, s_axi_rvalid, wakeEvent;
   wire attachPin, overcurrentPin, linePlusPin, lineMinusPin, routeToThisCtrl;
   wire busResetDrive, suspendDrive, resumeDrive;
   wire [1:0] s_axi_bresp, s_axi_rresp;
   wire [31:0] s_axi_rdata;
   wire [3:0] testSelect;
   int n_errors = 0, checks = 0, cyc = 0;
   usbrp_root_port u_usbrp_root_port
   (
      .sys_clk(sys_clk), .arst_n(arst_n), .s_axi_awaddr(s_axi_awaddr),
      .s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready), .s_axi_wdata(s_axi_wdata),
      .s_axi_wstrb(s_axi_wstrb), .s_axi_wvalid(s_axi_wvalid), .s_axi_wready(s_axi_wready),
      .s_axi_bresp(s_axi_bresp), .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready),
      .s_axi_araddr(s_axi_araddr), .s_axi_arvalid(s_axi_arvalid),
      .s_axi_arready(s_axi_arready), .s_axi_rdata(s_axi_rdata), .s_axi_rresp(s_axi_rresp),
      .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready), .attachPin(attachPin),
      .overcurrentPin(overcurrentPin), .linePlusPin(linePlusPin), .lineMinusPin(lineMinusPin),
      .eof2Disable(eof2Disable), .resetDoneHighSpeed(resetDoneHighSpeed),
      .routeToThisCtrl(routeToThisCtrl), .busResetDrive(busResetDrive),
      .suspendDrive(suspendDrive), .resumeDrive(resumeDrive), .testSelect(testSelect),
      .wakeEvent(wakeEvent)
   );
   usbrp_dev_model u_usbrp_dev_model
   (
      .present(present), .overCur(overCur), .wakeK(wakeK), .busResetDrive(busResetDrive),
      .resumeDrive(resumeDrive), .attachPin(attachPin), .overcurrentPin(overcurrentPin),
      .linePlusPin(linePlusPin), .lineMinusPin(lineMinusPin)
   );
   // Free-running system clock.
   initial
   begin
      sys_clk = 1'b0;
      forever #5 sys_clk = ~sys_clk;
   end
   // Latches the one-cycle wake pulse and cuts a hung run short.
   always @(posedge sys_clk)
   begin
      cyc <= cyc + 1;
      if (wakeEvent === 1'b1) sawWake <= 1'b1;
      if (cyc == 20000)
      begin
         n_errors++;
         end_sim();
      end
   end
   task automatic end_sim();
      $display("Comparisons %0d, mismatches %0d", checks, n_errors);
      if (n_errors == 0 && checks > 0) $display("TEST PASSED");
      else $display("TEST FAILED");
      $finish;
   endtask
   task automatic tick(input int n);
      repeat (n) @(posedge sys_clk);
   endtask
   // Both write channels offered together; each is dropped once taken.
   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      s_axi_awaddr <= a;
      s_axi_wdata <= d;
      {s_axi_awvalid, s_axi_wvalid, s_axi_bready} <= 3'h7;
      do
      begin
         @(posedge sys_clk);
         if (s_axi_awvalid && s_axi_awready) s_axi_awvalid <= 1'b0;
         if (s_axi_wvalid && s_axi_wready) s_axi_wvalid <= 1'b0;
         if (s_axi_bvalid && s_axi_bready) s_axi_bready <= 1'b0;
      end
      while (s_axi_awvalid || s_axi_wvalid || s_axi_bready);
   endtask
   // Compares the masked read word and the response at the answering edge.
   task automatic rd(input logic [7:0] a, input logic [31:0] m, e, input logic [1:0] r);
      s_axi_araddr <= a;
      {s_axi_arvalid, s_axi_rready} <= 2'h3;
      do
      begin
         @(posedge sys_clk);
         if (s_axi_arvalid && s_axi_arready) s_axi_arvalid <= 1'b0;
         if (s_axi_rvalid && s_axi_rready)
         begin
            s_axi_rready <= 1'b0;
            `CHK("rdata", e, s_axi_rdata & m);
            `CHK("rresp", r, s_axi_rresp);
         end
      end
      while (s_axi_arvalid || s_axi_rready);
   endtask
   // Main sequence; port writes from the 32'hFFF7C200 write on keep the three wake enables set.
   initial
   begin
      {s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = 5'h00;
      {arst_n, eof2Disable, present, overCur, wakeK, sawWake} = 6'h00;
      {s_axi_awaddr, s_axi_araddr, s_axi_wdata} = 48'h0;
      s_axi_wstrb = 4'hF;
      resetDoneHighSpeed = 1'b1;
      tick(16);
      arst_n <= 1'b1;
      tick(1);
      rd(PC, ALL, 32'h00003000, OK);
      wr(CFG, ALL);
      rd(CFG, ALL, 32'h00000001, OK);
      `CHK("route", 1'b1, routeToThisCtrl);
      rd(PC, 32'h00002000, 32'h00000000, OK);
      wr(CFG, 32'h00000000);
      rd(PC, 32'h00002000, 32'h00002000, OK);
      wr(CFG, 32'h00000001);
      rd(PC, 32'h00002000, 32'h00000000, OK);
      wr(PC, 32'h00002000);
      rd(PC, 32'h00002000, 32'h00002000, OK);
      wr(PC, 32'hFFF7C200);
      rd(PC, ALL, 32'h00771000, OK);
      `CHK("test", 4'h7, testSelect);
      wr(PC, 32'h00700000);
      tick(2);
      `CHK("test", 4'h0, testSelect);
      present <= 1'b1;
      tick(8);
      rd(PC, ALL, 32'h00701803, OK);
      wr(PC, 32'h00700006);
      rd(PC, ALL, 32'h00701801, OK);
      wr(PC, 32'h00700100);
      tick(2);
      `CHK("reset", 1'b1, busResetDrive);
      tick(1000);
      wr(PC, 32'h00700000);
      tick(4);
      `CHK("reset", 1'b0, busResetDrive);
      rd(PC, ALL, 32'h00701805, OK);
      wr(PC, 32'h00700084);
      tick(2);
      `CHK("susp", 1'b1, suspendDrive);
      wr(PC, 32'h00700004);
      tick(2);
      `CHK("susp", 1'b1, suspendDrive);
      wakeK <= 1'b1;
      tick(6);
      rd(PC, 32'h000000C0, 32'h000000C0, OK);
      `CHK("resume", 1'b1, resumeDrive);
      wakeK <= 1'b0;
      wr(PC, 32'h00700004);
      tick(20);
      `CHK("susp", 1'b0, suspendDrive);
      `CHK("resume", 1'b0, resumeDrive);
      wr(PC, 32'h00700084);
      wr(PC, 32'h00700104);
      tick(3);
      `CHK("susp", 1'b0, suspendDrive);
      tick(1000);
      wr(PC, 32'h00700000);
      tick(4);
      wr(PC, 32'h00700084);
      tick(2);
      overCur <= 1'b1;
      tick(8);
      `CHK("wake", 1'b1, sawWake);
      rd(PC, 32'h00000030, 32'h00000030, OK);
      wr(PC, 32'h00700020);
      rd(PC, 32'h00000034, 32'h00000010, OK);
      overCur <= 1'b0;
      tick(6);
      rd(PC, 32'h00000030, 32'h00000020, OK);
      wr(PC, 32'h00700120);
      tick(1000);
      wr(PC, 32'h00700000);
      tick(4);
      rd(PC, 32'h0000000C, 32'h00000004, OK);
      eof2Disable <= 1'b1;
      tick(1);
      eof2Disable <= 1'b0;
      tick(4);
      rd(PC, 32'h0000000C, 32'h00000008, OK);
      wr(PC, 32'h00700008);
      rd(PC, 32'h0000000C, 32'h00000000, OK);
      rd(8'h70, ALL, 32'h00000000, `USBRP_RESP_SLVERR);
      end_sim();
   end
endmodule
`default_nettype wire
